// ===== verilog/adm_ctrl.sv
/*
  Host controller for the asynchronous DRAM module: power-up pause and wake-up,
  single and page read/write, column-before-row refresh on a timer.
  Assumes the module's data pins resolve from dq_out/dq_oe in the bench,
  and that the user holds req steady until req_ready is seen.
*/
module adm_ctrl #(
  parameter int INIT_PAUSE = adm_pkg::INIT_PAUSE_CYC,
  parameter int IDLE_LIMIT = adm_pkg::IDLE_LIMIT_CYC,
  parameter int REFRESH_INT = adm_pkg::REFRESH_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire adm_pkg::adm_req_t req,
  output logic [adm_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid,
  output logic ready_for_use,
  output adm_pkg::adm_pins_t pins,
  output logic [adm_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [adm_pkg::DATA_W-1:0] dq_in
);
  localparam int CW = adm_pkg::CNT_W;

  // Counters are CW bits wide; larger counts would wrap silently
  if (INIT_PAUSE < 1 || IDLE_LIMIT < 1 || REFRESH_INT < 1 ||
      INIT_PAUSE >= (1 << CW) || IDLE_LIMIT >= (1 << CW) || REFRESH_INT >= (1 << CW))
  begin : g_bad_counts
    $error("adm_ctrl: counts out of range");
  end

  // Turns a cycle figure into a counter load
  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n - 1);
  endfunction

  adm_pkg::adm_state_t state_r;
  logic [CW-1:0] tmr_r;
  logic [CW-1:0] row_tmr_r;
  logic [CW-1:0] ref_tmr_r;
  logic [CW-1:0] idle_tmr_r;
  logic [3:0] wake_r;
  logic ref_pend_r;
  logic write_r;
  logic page_r;
  logic [1:0] bank_r;
  logic [adm_pkg::ADDR_W-1:0] col_r;
  logic [adm_pkg::DATA_W-1:0] wdata_r;
  logic [adm_pkg::ADDR_W-1:0] req_addr_row_r;
  logic rows_low;
  logic take;

  assign rows_low = (state_r == adm_pkg::ADM_ROW) || (state_r == adm_pkg::ADM_COL) ||
                    (state_r == adm_pkg::ADM_COL_PRE) || (state_r == adm_pkg::ADM_CBR_ROW) ||
                    (state_r == adm_pkg::ADM_WAKE);
  // Accept in idle, or at page precharge for the open bank and row only;
  // refresh and a due wake-up win in idle, so no request is lost to them
  assign req_ready = ((state_r == adm_pkg::ADM_IDLE) && !ref_pend_r && idle_tmr_r != '0) ||
                     ((state_r == adm_pkg::ADM_COL_PRE) && page_r && tmr_r == '0 &&
                      req.bank == bank_r &&
                      req.addr[2*adm_pkg::ADDR_W-1 -: adm_pkg::ADDR_W] == req_addr_row_r);
  assign take = req_valid && req_ready;

  // Refresh timer: request every interval, held until serviced
  always_ff @(posedge mclk)
  begin
    if (reset || state_r == adm_pkg::ADM_POWERUP)
    begin
      ref_tmr_r <= cyc(REFRESH_INT);
      ref_pend_r <= 1'b0;
    end
    else if (state_r == adm_pkg::ADM_CBR_SET)
    begin
      // Service clears the request, but an expiry in the same cycle sets it again
      ref_pend_r <= (ref_tmr_r == '0);
      ref_tmr_r <= (ref_tmr_r == '0) ? cyc(REFRESH_INT) : ref_tmr_r - 1'b1;
    end
    else if (ref_tmr_r == '0)
    begin
      ref_pend_r <= 1'b1;
      ref_tmr_r <= cyc(REFRESH_INT);
    end
    else
      ref_tmr_r <= ref_tmr_r - 1'b1;
  end

  // Idle watchdog: long inactivity forces a new wake-up
  always_ff @(posedge mclk)
  begin
    if (reset || rows_low)
      idle_tmr_r <= cyc(IDLE_LIMIT);
    else if (idle_tmr_r != '0)
      idle_tmr_r <= idle_tmr_r - 1'b1;
  end

  // Low time of the row strobe, checked before it may rise
  always_ff @(posedge mclk)
  begin
    if (reset || !rows_low)
      row_tmr_r <= cyc(adm_pkg::ROW_ACTIVE_CYC);
    else if (row_tmr_r != '0)
      row_tmr_r <= row_tmr_r - 1'b1;
  end

  // Main sequencer
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r <= adm_pkg::ADM_POWERUP;
      tmr_r <= cyc(INIT_PAUSE);
      wake_r <= 4'h0;
      ready_for_use <= 1'b0;
      write_r <= 1'b0;
      page_r <= 1'b0;
      bank_r <= 2'h0;
      col_r <= '0;
      wdata_r <= '0;
      rdata <= '0;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= 1'b0;
      if (tmr_r != '0)
        tmr_r <= tmr_r - 1'b1;
      case (state_r)
        adm_pkg::ADM_POWERUP:
          if (tmr_r == '0)
          begin
            state_r <= adm_pkg::ADM_WAKE;
            tmr_r <= cyc(adm_pkg::ROW_ACTIVE_CYC);
            wake_r <= 4'h0;
          end
        adm_pkg::ADM_WAKE:
          if (tmr_r == '0)
          begin
            wake_r <= wake_r + 4'h1;
            state_r <= adm_pkg::ADM_ROW_PRE;
            tmr_r <= cyc(adm_pkg::ROW_PRE_CYC);
          end
        adm_pkg::ADM_IDLE:
          if (idle_tmr_r == '0)
          begin
            ready_for_use <= 1'b0;
            wake_r <= 4'h0;
            state_r <= adm_pkg::ADM_WAKE;
            tmr_r <= cyc(adm_pkg::ROW_ACTIVE_CYC);
          end
          else if (ref_pend_r)
          begin
            state_r <= adm_pkg::ADM_CBR_SET;
            tmr_r <= cyc(adm_pkg::CBR_SETUP_CYC);
          end
          else if (take)
          begin
            write_r <= req.write;
            page_r <= req.keep_page;
            bank_r <= req.bank;
            col_r <= req.addr[adm_pkg::ADDR_W-1:0];
            wdata_r <= req.wdata;
            state_r <= adm_pkg::ADM_ROW;
            tmr_r <= cyc(adm_pkg::ROW_HOLD_CYC);
          end
        adm_pkg::ADM_ROW:
          if (tmr_r == '0)
          begin
            state_r <= adm_pkg::ADM_COL;
            // Longest of column low, access and write lead covers both paths
            tmr_r <= cyc(adm_pkg::ACCESS_CYC);
          end
        adm_pkg::ADM_COL:
          if (tmr_r == '0)
          begin
            if (!write_r)
            begin
              rdata <= dq_in; // Sampled before column strobe rises
              rdata_valid <= 1'b1;
            end
            state_r <= adm_pkg::ADM_COL_PRE;
            tmr_r <= cyc(adm_pkg::COL_PRE_CYC);
          end
        adm_pkg::ADM_COL_PRE:
          if (take)
          begin
            write_r <= req.write;
            col_r <= req.addr[adm_pkg::ADDR_W-1:0];
            wdata_r <= req.wdata;
            page_r <= req.keep_page;
            state_r <= adm_pkg::ADM_COL;
            tmr_r <= cyc(adm_pkg::ACCESS_CYC);
          end
          else if (tmr_r == '0 && row_tmr_r == '0)
          begin
            // No acceptable follow-on closes the page, so refresh waits only this long
            state_r <= adm_pkg::ADM_ROW_PRE;
            tmr_r <= cyc(adm_pkg::ROW_PRE_CYC);
          end
        adm_pkg::ADM_ROW_PRE:
          if (tmr_r == '0)
          begin
            if (wake_r != 4'h0 && wake_r < 4'(adm_pkg::WAKE_CYCLES))
            begin
              state_r <= adm_pkg::ADM_WAKE;
              tmr_r <= cyc(adm_pkg::ROW_ACTIVE_CYC);
            end
            else
            begin
              if (wake_r != 4'h0)
                ready_for_use <= 1'b1;
              wake_r <= 4'h0;
              state_r <= adm_pkg::ADM_IDLE;
            end
          end
        adm_pkg::ADM_CBR_SET:
          if (tmr_r == '0)
          begin
            state_r <= adm_pkg::ADM_CBR_ROW;
            tmr_r <= cyc(adm_pkg::ROW_ACTIVE_CYC);
          end
        adm_pkg::ADM_CBR_ROW:
          if (tmr_r == '0)
          begin
            state_r <= adm_pkg::ADM_ROW_PRE;
            tmr_r <= cyc(adm_pkg::ROW_PRE_CYC);
          end
        default:
          state_r <= adm_pkg::ADM_POWERUP;
      endcase
    end
  end

  // Pin drive: one bank pair member at a time, write line set in the same cycle as the column fall
  always_comb
  begin
    pins.row_strobe_n = 4'hF;
    pins.col_strobe_n = 4'hF;
    pins.write_enable_n = 1'b1;
    pins.addr = '0;
    dq_out = wdata_r;
    dq_oe = 1'b0;
    if (rows_low)
    begin
      if (state_r == adm_pkg::ADM_WAKE || state_r == adm_pkg::ADM_CBR_ROW)
        pins.row_strobe_n = 4'hA; // Strobes 0 and 2 only
      else
        pins.row_strobe_n = ~(4'h1 << bank_r);
    end
    if (state_r == adm_pkg::ADM_ROW)
      pins.addr = req_addr_row_r;
    if (state_r == adm_pkg::ADM_COL)
    begin
      pins.col_strobe_n = 4'h0;
      pins.addr = col_r;
      pins.write_enable_n = !write_r;
      dq_oe = write_r;
    end
    // Plain counter refresh only, never hidden or counter test
    if (state_r == adm_pkg::ADM_CBR_SET || state_r == adm_pkg::ADM_CBR_ROW)
      pins.col_strobe_n = 4'h0; // row-only refresh not used
  end

  // Row field held for the row strobe fall
  always_ff @(posedge mclk)
  begin
    if (reset)
      req_addr_row_r <= '0;
    else if (take && state_r == adm_pkg::ADM_IDLE)
      req_addr_row_r <= req.addr[2*adm_pkg::ADDR_W-1 -: adm_pkg::ADDR_W];
  end
endmodule // adm_ctrl

// ===== verilog/adm_pkg.sv
/*
  Constants, states and carrier types of the DRAM module controller.
  Assumes a 25 MHz mclk and a module with nine multiplexed address pins.
*/
// Notes on behaviour
// - Never hold row_strobe_0 with 1, or 2 with 3, low together.
// - After power-up wait 200 us, then give eight row strobe cycles.
// - After over 4 ms idle, repeat the eight-cycle wake-up.
// - Row field latched on row strobe fall, column field on column strobe fall.
// - Row and column strobes keep minimum low times; row strobe keeps precharge.
// - Write line stays high around the column strobe pulse of a read.
// - After write line falls, strobes stay low for their write lead times.
// - Page mode keeps row open while column strobe toggles across 512 columns.
// - Reads and writes may mix freely within one page.
// - Refresh all 512 rows every 8 ms, one row per 15.6 us.
// - Row-only refresh keeps column strobe high throughout.
// - Hidden refresh: column strobe held low, row precharge, then counter refresh.
// - Counter test uses internal row and external column, after eight counter refreshes.
// - Counter test writes zeros, reads, writes ones, reads, then complements.
// - A read ends meeting write hold after column or after row strobe rise.
package adm_pkg;
  localparam int CLK_MHZ = 25;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  // Timing figures in ns or us
  localparam int INIT_PAUSE_US = 200;
  localparam int IDLE_LIMIT_US = 4000;
  localparam int REFRESH_US_X10 = 156;
  localparam int WAKE_CYCLES = 8;
  localparam int ROW_HOLD_NS = 15;
  localparam int ROW_ACTIVE_NS = 100;
  localparam int COL_ACTIVE_NS = 25;
  localparam int ROW_PRECHARGE_NS = 70;
  localparam int COL_PRECHARGE_NS = 15;
  localparam int COL_BEFORE_ROW_NS = 10;
  localparam int ACCESS_NS = 100;
  localparam int WRITE_LEAD_NS = 25;
  // Cycle counts: least times round up
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_ACTIVE_CYC = (ROW_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_ACTIVE_CYC = (COL_ACTIVE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_PRE_CYC = (ROW_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int COL_PRE_CYC = (COL_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CBR_SETUP_CYC = (COL_BEFORE_ROW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_LEAD_CYC = (WRITE_LEAD_NS + CLK_NS - 1) / CLK_NS;
  // Longest times round down
  localparam int INIT_PAUSE_CYC = INIT_PAUSE_US * CLK_MHZ;
  localparam int IDLE_LIMIT_CYC = IDLE_LIMIT_US * CLK_MHZ;
  localparam int REFRESH_CYC = REFRESH_US_X10 * CLK_MHZ / 10;
  localparam int CNT_W = 18;

  typedef enum logic [8:0] {
    ADM_POWERUP  = 9'h001,
    ADM_IDLE     = 9'h002,
    ADM_ROW      = 9'h004,
    ADM_COL      = 9'h008,
    ADM_COL_PRE  = 9'h010,
    ADM_ROW_PRE  = 9'h020,
    ADM_CBR_SET  = 9'h040,
    ADM_CBR_ROW  = 9'h080,
    ADM_WAKE     = 9'h100
  } adm_state_t;

  // One user request
  typedef struct packed {
    logic write;
    logic [2*ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] bank;
    logic keep_page;
  } adm_req_t;

  // Pins driven toward the module
  typedef struct packed {
    logic [3:0] row_strobe_n;
    logic [3:0] col_strobe_n;
    logic write_enable_n;
    logic [ADDR_W-1:0] addr;
  } adm_pins_t;
endpackage

// ===== sim/adm_ctrl_assertions.sv
/*
  Port checker for adm_ctrl: strobe pairing, pulse widths, write line, refresh gaps.
  Assumes it is bound to adm_ctrl and sees only its ports.
*/
module adm_ctrl_assertions #(
  parameter int REFRESH_INT = 60
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire adm_pkg::adm_req_t req,
  input wire logic [adm_pkg::DATA_W-1:0] rdata,
  input wire logic rdata_valid,
  input wire logic ready_for_use,
  input wire adm_pkg::adm_pins_t pins,
  input wire logic [adm_pkg::DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic [adm_pkg::DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [15:0] gap_r;
  wire logic busy = !(&pins.row_strobe_n);
  // Idle cycles since a row strobe was last low; refresh must keep this short
  always_ff @(posedge mclk)
  begin
    if (reset || busy || !ready_for_use)
      gap_r <= 16'h0000;
    else
      gap_r <= gap_r + 16'h0001;
  end
  pair_low_a: assert property (pins.row_strobe_n[0] || pins.row_strobe_n[1])
    else $error("row strobes 0 and 1 low together");
  upper_pair_a: assert property (pins.row_strobe_n[2] || pins.row_strobe_n[3])
    else $error("row strobes 2 and 3 low together");
  init_pause_a: assert property ($fell(reset) |-> (&pins.row_strobe_n)[*8])
    else $error("row strobe active during power-up pause");
  early_use_a: assert property (!ready_for_use |-> !req_ready)
    else $error("request taken before wake-up done");
  row_width_a: assert property (
    $fell(pins.row_strobe_n[0]) |-> (!pins.row_strobe_n[0])[*3])
    else $error("row strobe pulse too short");
  row_pre_a: assert property ($rose(pins.row_strobe_n[0]) |-> (pins.row_strobe_n[0])[*2])
    else $error("row precharge too short");
  read_line_a: assert property (
    $fell(pins.col_strobe_n[0]) && busy && !dq_oe |-> pins.write_enable_n)
    else $error("write line low in a read");
  we_steady_a: assert property (
    !pins.col_strobe_n[0] && busy |=> pins.col_strobe_n[0] || $stable(pins.write_enable_n))
    else $error("write line moved under column strobe");
  write_data_a: assert property (
    $fell(pins.col_strobe_n[0]) && busy && !pins.write_enable_n |-> dq_oe)
    else $error("write without data driven");
  cbr_setup_a: assert property (
    $fell(pins.row_strobe_n[0]) && !pins.col_strobe_n[0] |-> $past(pins.col_strobe_n[0]) == 1'b0)
    else $error("column strobe late for counter refresh");
  refresh_gap_a: assert property (gap_r < REFRESH_INT + 32)
    else $error("refresh overdue");
  read_done_c: cover property (rdata_valid);
  write_seen_c: cover property ($fell(pins.col_strobe_n[0]) && dq_oe);
  cbr_seen_c: cover property ($fell(pins.row_strobe_n[0]) && !pins.col_strobe_n[0]);
endmodule // adm_ctrl_assertions

// ===== sim/adm_dram_model.sv
/*
  Behavioural DRAM module on the far side of adm_ctrl.
  Assumes strobes act as one word; data appears ACC_NS after a read starts.
*/
module adm_dram_model #(
  parameter int ACC_NS = 0
) (
  input wire adm_pkg::adm_pins_t pins,
  input wire logic [adm_pkg::DATA_W-1:0] dq_out,
  output logic [adm_pkg::DATA_W-1:0] dq_in = 32'h00000000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [bit [19:0]];
  logic [8:0] row_r = 9'h000;
  logic [8:0] col_r = 9'h000;
  logic [8:0] ctr_r = 9'h000;
  logic [1:0] bank_r = 2'h0;
  logic rd = 1'b0;
  int refreshes = 0;
  int clashes = 0;
  wire logic row_low = !(&pins.row_strobe_n);
  wire logic col_low = !(&pins.col_strobe_n);
  // Row fall: column already low means counter refresh, else latch row.
  // Pins all settle within the edge's time step, so they are read 1 ns later.
  always @(posedge row_low)
  begin
    #1;
    if (col_low)
    begin
      refreshes++;
      ctr_r = ctr_r + 9'h001;
    end
    else
    begin
      row_r = pins.addr;
      bank_r = pins.row_strobe_n[0] ? (pins.row_strobe_n[1] ?
        (pins.row_strobe_n[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
    end
  end
  // Column fall is ignored without an open row, so counter refresh keeps outputs off
  always @(posedge col_low)
  begin
    #1;
    col_r = pins.addr;
    rd = row_low && pins.write_enable_n;
    if (row_low && !pins.write_enable_n)
      mem[{bank_r, row_r, col_r}] = dq_out;
  end
  always @(negedge col_low) rd = 1'b0;
  // Unlatched output; a released bus flips so stale data cannot match
  always @(rd)
    dq_in <= #(ACC_NS) (rd ? (mem.exists({bank_r, row_r, col_r}) ?
      mem[{bank_r, row_r, col_r}] : 32'h00000000) : ~dq_in);
  // Count forbidden pairs of row strobes
  always @(pins.row_strobe_n)
    if (!(|pins.row_strobe_n[1:0]) || !(|pins.row_strobe_n[3:2])) clashes++;
endmodule // adm_dram_model

// ===== sim/adm_ctrl_tb_top.sv
/*
  Self-checking bench for adm_ctrl with the behavioural DRAM model.
  Assumes short pause and refresh counts; expectations held in a table.
*/
module adm_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready, rdata_valid, ready_for_use, dq_oe;
  adm_pkg::adm_req_t req = '0;
  logic [31:0] rdata, dq_out, dq_in;
  adm_pkg::adm_pins_t pins;
  logic [31:0] exp_mem [bit [19:0]];
  logic [19:0] keys [24];
  int fails = 0;
  int cmp_count = 0;
  int base;
  // Idle limit below the refresh interval so the idle wake-up is reachable
  adm_ctrl #(.INIT_PAUSE(20), .IDLE_LIMIT(40), .REFRESH_INT(60)) adm_ctrl_inst (
    .mclk(mclk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rdata(rdata), .rdata_valid(rdata_valid), .ready_for_use(ready_for_use), .pins(pins),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  adm_dram_model #(.ACC_NS(90)) adm_dram_model_inst (.pins(pins), .dq_out(dq_out),
    .dq_in(dq_in));
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] expect_of(input logic [19:0] k);
    return exp_mem.exists(k) ? exp_mem[k] : 32'h00000000;
  endfunction
  // One request held until taken; a read is checked against the table
  task automatic access(input logic w, input logic [19:0] k, input logic [31:0] d,
    input logic kp);
    int n;
    @(posedge mclk);
    #1 req = {w, k[17:0], d, k[19:18], kp};
    req_valid = 1'b1;
    n = 0;
    @(negedge mclk);
    while (req_ready !== 1'b1 && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    chk({31'h0, req_ready}, 32'h1);
    @(posedge mclk);
    #1 req_valid = 1'b0;
    if (w)
      exp_mem[k] = d;
    else
    begin
      n = 0;
      while (rdata_valid !== 1'b1 && n < 40)
      begin
        @(negedge mclk);
        n++;
      end
      chk({31'h0, rdata_valid}, 32'h1);
      chk(rdata, expect_of(k));
    end
  endtask
  task automatic wait_ready;
    repeat (300) if (ready_for_use !== 1'b1) @(negedge mclk);
    chk({31'h0, ready_for_use}, 32'h1);
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(32'had4716a7));
    repeat (8) @(posedge mclk);
    #1 reset = 1'b0;
    chk({31'h0, ready_for_use}, 32'h0);
    wait_ready();
    for (int b = 0; b < 4; b++)
    begin
      access(1'b1, {b[1:0], 18'h3FFFF}, $urandom, 1'b0);
      access(1'b1, {b[1:0], 18'h00000}, $urandom, 1'b0);
      access(1'b0, {b[1:0], 18'h3FFFF}, 32'h0, 1'b0);
      access(1'b0, {b[1:0], 18'h00000}, 32'h0, 1'b0);
    end
    foreach (keys[i])
    begin
      keys[i] = 20'($urandom);
      access(1'b1, keys[i], $urandom, 1'b0);
    end
    for (int i = 23; i >= 0; i--)
      access(1'($urandom_range(1)), keys[i], $urandom, 1'b0);
    foreach (keys[i])
      access(1'b0, keys[i], 32'h0, 1'b0);
    base = $urandom;
    for (int i = 0; i < 8; i++)
      access(i[0], {base[19:9], 9'($urandom)}, $urandom, i < 7);
    base = adm_dram_model_inst.refreshes;
    repeat (300) @(posedge mclk);
    chk({31'h0, adm_dram_model_inst.refreshes - base >= 4}, 32'h1);
    #1 reset = 1'b1;
    repeat (2) @(posedge mclk);
    chk({31'h0, ready_for_use}, 32'h0);
    #1 reset = 1'b0;
    wait_ready();
    // Left idle past the limit, the controller must drop ready and wake up again
    base = 0;
    while (ready_for_use === 1'b1 && base < 100)
    begin
      @(negedge mclk);
      base++;
    end
    chk({31'h0, ready_for_use}, 32'h0);
    wait_ready();
    access(1'b0, keys[0], 32'h0, 1'b0);
    chk(adm_dram_model_inst.clashes, 32'h0);
    report_and_stop();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #2000000;
    fails++;
    report_and_stop();
  end
endmodule // adm_ctrl_tb_top
bind adm_ctrl adm_ctrl_assertions #(.REFRESH_INT(REFRESH_INT)) adm_ctrl_assertions_inst (
  .mclk(mclk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req(req),
  .rdata(rdata), .rdata_valid(rdata_valid), .ready_for_use(ready_for_use), .pins(pins),
  .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
